/* File: dms_pkg.sv */
package dms_pkg;
    localparam int OPW = 18;
    localparam int PW = 37;
    localparam int ZW = 38;
    localparam int AW = 44;
    localparam int RW = 72;
    localparam int SHW = 32;
    localparam int FW = 74;
    localparam int NGRP = 4;
    localparam logic [11:0] OFS_CTRL0 = 12'h000;
    localparam logic [11:0] OFS_CTRL1 = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h1FFF_FFFF;
    localparam int F_MODE = 0;
    localparam int F_WIDTH = 3;
    localparam int F_SUB1 = 6;
    localparam int F_ACCSUB = 7;
    localparam int F_CHAIN = 8;
    localparam int F_TAP = 9;
    localparam int F_LOOP = 10;
    localparam int F_RND = 11;
    localparam int F_SAT = 12;
    localparam int F_BYP_IN = 13;
    localparam int F_BYP_PIPE = 14;
    localparam int F_BYP_OUT = 15;
    localparam int F_GRP = 16;
    localparam int F_RND_POS = 18;
    localparam int F_SAT_W = 23;
    localparam int LOOP_HI = 35;
    localparam int LOOP_LO = 18;
    typedef enum logic [2:0] {
        MODE_MULT = 3'b000,
        MODE_ADD2 = 3'b001,
        MODE_ADD4 = 3'b010,
        MODE_MAC = 3'b011,
        MODE_SHIFT = 3'b100
    } dms_mode_t;
    typedef enum logic [2:0] {
        WID_9 = 3'b000,
        WID_12 = 3'b001,
        WID_18 = 3'b010,
        WID_36 = 3'b011,
        WID_DBL = 3'b100
    } dms_width_t;
    typedef enum logic [2:0] {
        SH_LSL = 3'b000,
        SH_LSR = 3'b001,
        SH_ASL = 3'b010,
        SH_ASR = 3'b011,
        SH_ROT = 3'b100
    } dms_shift_t;
endpackage

/* File: dms_stage.sv */
`timescale 1ns/100ps
module dms_stage
    import dms_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and clear
    input wire logic clock,
    input wire logic clr,
    // Control
    input wire logic ena,
    input wire logic bypass,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] held
);
    generate
        if (W < 1) begin : g_chk
            $error("Stage width must be positive.");
        end
    endgenerate

    always_ff @(posedge clock or posedge clr) begin
        if (clr) begin
            held <= '0;
        end else if (ena) begin
            held <= d;
        end
    end

    assign q = bypass ? d : held;
endmodule

/* File: dms_block.sv */
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module dms_block
    import dms_pkg::*;
#(
    parameter int GROUPS = NGRP
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shared register controls
    input wire logic [3:0] ena,
    input wire logic [3:0] aclr,
    // Per-half dynamic controls
    input wire logic [1:0] sign_a,
    input wire logic [1:0] sign_b,
    input wire logic [1:0][2:0] shift_op,
    // Operands
    input wire logic [1:0][3:0][17:0] data_a,
    input wire logic [1:0][3:0][17:0] data_b,
    // Cascades
    input wire logic [17:0] scan_in,
    output logic [17:0] scan_out,
    input wire logic [43:0] chain_in,
    output logic [43:0] chain_out,
    // Results
    output logic [1:0][71:0] result
);
    generate
        if (GROUPS != NGRP) begin : g_chk
            $error("The block serves exactly four control groups.");
        end
    endgenerate

    function automatic logic signed [72:0] ext(input logic [35:0] x, input logic s,
                                               input int w);
        logic [72:0] m;
        logic [72:0] v;
        m = (73'h1 << w) - 73'h1;
        v = {37'h0, x} & m;
        if (s && x[w-1]) begin
            v = v | ~m;
        end
        return $signed(v);
    endfunction

    function automatic logic [71:0] mulx(input logic [35:0] a, input logic [35:0] b,
                                         input logic sa, input logic sb, input int w);
        logic signed [72:0] pr;
        pr = ext(a, sa, w) * ext(b, sb, w);
        return pr[71:0];
    endfunction

    function automatic logic [43:0] widen(input logic [37:0] z, input logic s);
        return s ? {{6{z[37]}}, z} : {6'h00, z};
    endfunction

    logic rst_meta_b_r;
    logic rst_sync_b_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_b_r <= 1'b1;
            rst_sync_b_r <= rst_meta_b_r;
        end
    end

    logic [1:0][31:0] ctrl_r;
    logic [1:0] sat_sticky_r;
    logic [1:0] sat_hit;
    logic [31:0] prdata_r;
    logic err_r;
    logic wr;
    logic mapped;
    logic [31:0] rd_val;

    assign wr = psel & penable & pwrite;
    assign mapped = (paddr == OFS_CTRL0) | (paddr == OFS_CTRL1) | (paddr == OFS_STATUS);
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = psel & penable & err_r;

    always_ff @(posedge clock or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            ctrl_r[0] <= CTRL_RESET;
            ctrl_r[1] <= CTRL_RESET;
        end else if (wr && paddr == OFS_CTRL0) begin
            ctrl_r[0] <= pwdata & CTRL_MASK;
        end else if (wr && paddr == OFS_CTRL1) begin
            ctrl_r[1] <= pwdata & CTRL_MASK;
        end
    end

    // A saturation seen in the clearing cycle survives the write-one clear.
    always_ff @(posedge clock or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            sat_sticky_r <= 2'h0;
        end else if (wr && paddr == OFS_STATUS) begin
            sat_sticky_r <= (sat_sticky_r & ~pwdata[1:0]) | sat_hit;
        end else begin
            sat_sticky_r <= sat_sticky_r | sat_hit;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == OFS_CTRL0) begin
            rd_val = ctrl_r[0];
        end else if (paddr == OFS_CTRL1) begin
            rd_val = ctrl_r[1];
        end else if (paddr == OFS_STATUS) begin
            rd_val = {30'h0, sat_sticky_r};
        end
    end

    // Read data is caught in the setup cycle so that prdata comes from a flop.
    always_ff @(posedge clock or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            err_r <= ~mapped;
        end
    end

    logic [1:0][3:0][17:0] a_held;
    logic [1:0][71:0] out_held;
    logic [1:0][43:0] chain_sum;

    assign scan_out = a_held[1][3];
    assign chain_out = chain_sum[1];

    // Two identical halves, two pair units each.
    // Halves share the control groups; half 1 also takes its tap and chain inputs from half 0.
    for (genvar h = 0; h < 2; h++) begin : g_half
        logic [31:0] cf;
        dms_mode_t mode;
        dms_width_t wid;
        dms_shift_t op;
        logic [1:0] grp;
        logic clr;
        logic en;
        logic sg;
        logic [3:0][17:0] a_src;
        logic [3:0][17:0] b_src;
        logic [3:0][17:0] av;
        logic [3:0][17:0] bv;
        logic [3:0][17:0] b_held;
        logic [FW-1:0] first;
        logic [FW-1:0] pq;
        logic [FW-1:0] pipe_held;
        logic [43:0] csum;
        logic [43:0] rs;
        logic [71:0] out_d;
        logic [71:0] out_q;
        logic sat_now;

        assign cf = ctrl_r[h];
        assign mode = dms_mode_t'(cf[F_MODE +: 3]);
        assign wid = dms_width_t'(cf[F_WIDTH +: 3]);
        assign op = dms_shift_t'(shift_op[h]);
        assign grp = cf[F_GRP +: 2];
        // Group clear reaches every stage of the half.
        assign clr = aclr[grp] | ~rst_sync_b_r;
        assign en = ena[grp];
        // Product signed if either operand signed.
        assign sg = sign_a[h] | sign_b[h];

        always_comb begin
            a_src = data_a[h];
            b_src = data_b[h];
            // Tap line from the previous input register.
            if (cf[F_TAP]) begin
                a_src[0] = (h == 0) ? scan_in : a_held[0][3];
                for (int k = 1; k < 4; k++) begin
                    a_src[k] = a_held[h][k-1];
                end
            end
            // Only multiplier zero may loop back.
            if (cf[F_LOOP] && mode == MODE_ADD2) begin
                b_src[0] = out_held[h][LOOP_HI:LOOP_LO];
            end
        end

        dms_stage #(.W(2 * 4 * OPW)) u_in (
            .clock(clock),
            .clr(clr),
            .ena(en),
            .bypass(cf[F_BYP_IN]),
            .d({b_src, a_src}),
            .q({bv, av}),
            .held({b_held, a_held[h]})
        );

        always_comb begin
            logic [71:0] t;
            logic [71:0] u;
            logic [37:0] s2;
            logic [63:0] rot;
            logic [31:0] sv;
            int w;
            int n;
            t = '0;
            u = '0;
            s2 = '0;
            rot = '0;
            sv = {av[1][13:0], av[0]};
            w = 18;
            n = 2;
            first = '0;
            case (mode)
                MODE_MULT: begin
                    if (wid == WID_36 || wid == WID_DBL) begin
                        t = mulx({av[1], av[0]}, {bv[1], bv[0]}, sign_a[h], sign_b[h], 36);
                        first = {2'b00, t};
                    end else begin
                        if (wid == WID_9) begin
                            w = 9;
                            n = 4;
                        end else if (wid == WID_12) begin
                            w = 12;
                            n = 3;
                        end
                        for (int k = 0; k < 4; k++) begin
                            if (k < n) begin
                                t = mulx({18'h0, av[k]}, {18'h0, bv[k]},
                                         sign_a[h], sign_b[h], w);
                                u = (t & ((72'h1 << (2 * w)) - 72'h1)) << (2 * w * k);
                                first = first | {2'b00, u};
                            end
                        end
                    end
                end
                MODE_ADD2, MODE_ADD4, MODE_MAC: begin
                    for (int j = 0; j < 2; j++) begin
                        t = mulx({18'h0, av[2*j]}, {18'h0, bv[2*j]}, sign_a[h], sign_b[h], 18);
                        u = mulx({18'h0, av[2*j+1]}, {18'h0, bv[2*j+1]},
                                 sign_a[h], sign_b[h], 18);
                        s2 = cf[F_SUB1] ? t[37:0] - u[37:0] : t[37:0] + u[37:0];
                        first[PW*j +: PW] = s2[PW-1:0];
                    end
                end
                MODE_SHIFT: begin
                    case (op)
                        SH_LSL, SH_ASL: first[31:0] = sv << bv[0][4:0];
                        SH_LSR: first[31:0] = sv >> bv[0][4:0];
                        SH_ASR: first[31:0] = $signed(sv) >>> bv[0][4:0];
                        SH_ROT: begin
                            rot = {sv, sv} << bv[0][4:0];
                            first[31:0] = rot[63:32];
                        end
                        default: first[31:0] = 32'h0000_0000;
                    endcase
                end
                default: first = '0;
            endcase
        end

        dms_stage #(.W(FW)) u_pipe (
            .clock(clock),
            .clr(clr),
            .ena(en),
            .bypass(cf[F_BYP_PIPE]),
            .d(first),
            .q(pq),
            .held(pipe_held)
        );

        always_comb begin
            logic [37:0] z;
            logic [43:0] wv;
            logic [43:0] chin;
            logic [43:0] hi;
            logic [43:0] lo;
            logic [43:0] m;
            logic [4:0] pos;
            logic [5:0] sw;
            hi = '0;
            lo = '0;
            m = '0;
            z = (sg ? {pq[2*PW-1], pq[2*PW-1:PW]} : {1'b0, pq[2*PW-1:PW]})
                + (sg ? {pq[PW-1], pq[PW-1:0]} : {1'b0, pq[PW-1:0]});
            wv = widen(z, sg);
            if (mode == MODE_MAC) begin
                wv = cf[F_ACCSUB] ? out_held[h][43:0] - wv : out_held[h][43:0] + wv;
            end
            chin = (h == 0) ? chain_in : chain_sum[0];
            csum = cf[F_CHAIN] ? wv + chin : wv;
            // Round then saturate ahead of output.
            rs = csum;
            pos = cf[F_RND_POS +: 5];
            sw = cf[F_SAT_W +: 6];
            sat_now = 1'b0;
            if (cf[F_RND] && pos != 5'h00) begin
                m = (44'h1 << pos) - 44'h1;
                rs = (rs + (44'h1 << (pos - 5'h01))) & ~m;
            end
            if (cf[F_SAT] && sw != 6'h00 && sw < 6'h2C) begin
                if (sg) begin
                    hi = (44'h1 << (sw - 6'h01)) - 44'h1;
                    lo = ~hi;
                    if ($signed(rs) > $signed(hi)) begin
                        rs = hi;
                        sat_now = 1'b1;
                    end else if ($signed(rs) < $signed(lo)) begin
                        rs = lo;
                        sat_now = 1'b1;
                    end
                end else begin
                    hi = (44'h1 << sw) - 44'h1;
                    if (rs > hi) begin
                        rs = hi;
                        sat_now = 1'b1;
                    end
                end
            end
        end

        assign chain_sum[h] = csum;

        always_comb begin
            case (mode)
                MODE_MULT: out_d = pq[71:0];
                // Pair sums leave as 36 bits each.
                MODE_ADD2: out_d = {pq[PW+35:PW], pq[35:0]};
                MODE_ADD4, MODE_MAC: out_d = {{28{rs[43] & sg}}, rs};
                MODE_SHIFT: out_d = {40'h00_0000_0000, pq[31:0]};
                default: out_d = '0;
            endcase
        end

        // The accumulator needs its register, so bypass is refused in that mode.
        dms_stage #(.W(RW)) u_out (
            .clock(clock),
            .clr(clr),
            .ena(en),
            .bypass(cf[F_BYP_OUT] & (mode != MODE_MAC)),
            .d(out_d),
            .q(out_q),
            .held(out_held[h])
        );

        assign sat_hit[h] = sat_now & en & (mode == MODE_ADD4 || mode == MODE_MAC);
        assign result[h] = out_q;
    end
endmodule

/* File: dms_tb_cfg.svh */
// Settings used by the bench; bypassed stages show a result in the same cycle.
localparam logic [31:0] C_MUL = 32'h0000_E010;
localparam logic [31:0] C_ADD2 = 32'h0001_E051;
localparam logic [31:0] C_ADD4 = 32'h0000_E112;
localparam logic [31:0] C_SHF = 32'h0001_E01C;
localparam logic [31:0] C_REG = 32'h0000_0010;
localparam logic [31:0] C_MAC = 32'h0000_6013;
localparam logic [31:0] C_HLD = 32'h0001_0010;
localparam logic [31:0] C_RS = 32'h1210_F812;
localparam logic [31:0] C_TAP = 32'h0001_E210;
function automatic logic [31:0] dms_shf(input logic [31:0] v, input logic [4:0] n,
                                        input logic [2:0] op);
    logic [63:0] t;
    t = {v, v} << n;
    case (op)
        3'h1: return v >> n;
        3'h3: return $signed(v) >>> n;
        3'h4: return t[63:32];
        default: return v << n;
    endcase
endfunction

/* File: dms_block_properties.sv */
`timescale 1ns/100ps
module dms_block_properties
    import dms_pkg::*;
#(
    parameter int GROUPS = NGRP
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Datapath
    input wire logic [3:0] ena,
    input wire logic [3:0] aclr,
    input wire logic [1:0] sign_a,
    input wire logic [1:0] sign_b,
    input wire logic [1:0][2:0] shift_op,
    input wire logic [1:0][3:0][17:0] data_a,
    input wire logic [1:0][3:0][17:0] data_b,
    input wire logic [43:0] chain_in,
    input wire logic [1:0][71:0] result
);
    `include "dms_tb_cfg.svh"
    logic [31:0] c0_r;
    logic [31:0] c1_r;
    logic [1:0][3:0][35:0] prod;
    logic [37:0] z0;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            c0_r <= '0;
            c1_r <= '0;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == OFS_CTRL0) c0_r <= pwdata & CTRL_MASK;
            if (paddr == OFS_CTRL1) c1_r <= pwdata & CTRL_MASK;
        end
    end
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            for (int k = 0; k < 4; k++) prod[h][k] = data_a[h][k] * data_b[h][k];
        end
    end
    assign z0 = prod[0][0] + prod[0][1] + prod[0][2] + prod[0][3];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_MUL: assert property (c0_r == C_MUL && !sign_a[0] && !sign_b[0]
        |-> result[0] == {prod[0][1], prod[0][0]}) else $error("independent products wrong");
    AST_ADD2: assert property (c1_r == C_ADD2 && !sign_a[1] && !sign_b[1]
        |-> result[1] == {36'(prod[1][2] - prod[1][3]), 36'(prod[1][0] - prod[1][1])})
        else $error("pair difference wrong");
    AST_CHAIN: assert property (c0_r == C_ADD4 && !sign_a[0] && !sign_b[0]
        |-> result[0][43:0] == chain_in + z0) else $error("chained sum wrong");
    AST_SHIFT: assert property (c1_r == C_SHF
        |-> result[1][31:0] == dms_shf({data_a[1][1][13:0], data_a[1][0]},
        data_b[1][0][4:0], shift_op[1])) else $error("shift result wrong");
    AST_MAC: assert property ((c0_r == C_MAC && ena[0] && !aclr[0] && !sign_a[0]
        && !sign_b[0]) ##1 !aclr[0] |-> result[0][43:0] == $past(result[0][43:0])
        + 44'($past(z0))) else $error("accumulate step wrong");
    AST_LATENCY: assert property ((c0_r == C_REG && ena[0] && !aclr[0]
        && !sign_a[0] && !sign_b[0]) [*4] |-> result[0][35:0] == $past(prod[0][0], 3))
        else $error("registered latency wrong");
    AST_CLEAR: assert property (aclr[c0_r[17:16]] && !c0_r[15] |-> result[0] == '0)
        else $error("clear did not empty output");
    AST_HOLD: assert property (!ena[c1_r[17:16]] && !c1_r[15]
        && !(psel && penable && pwrite) |=> aclr[c1_r[17:16]] || $stable(result[1]))
        else $error("output moved while disabled");
endmodule
bind dms_block dms_block_properties #(.GROUPS(GROUPS)) u_props (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .ena(ena), .aclr(aclr),
    .sign_a(sign_a), .sign_b(sign_b), .shift_op(shift_op), .data_a(data_a),
    .data_b(data_b), .chain_in(chain_in), .result(result));

/* File: dms_fabric.sv */
`timescale 1ns/100ps
module dms_fabric (
    // Clock
    input wire logic clock,
    // Operand range
    input wire logic narrow,
    // Operands
    output logic [1:0][3:0][17:0] data_a,
    output logic [1:0][3:0][17:0] data_b
);
    integer seed = 32'hF812;
    initial begin
        data_a = '0;
        data_b = '0;
    end
    // two's complement, fit
    // Words are raw two's complement; dropping the top bit keeps unsigned sums in 36 bits.
    always @(posedge clock) begin
        for (int h = 0; h < 2; h++) begin
            for (int k = 0; k < 4; k++) begin
                data_a[h][k] <= 18'($random(seed)) & (narrow ? 18'h1FFFF : 18'h3FFFF);
                data_b[h][k] <= 18'($random(seed)) & (narrow ? 18'h1FFFF : 18'h3FFFF);
            end
        end
    end
endmodule

/* File: test_dms_multiply_add_slice.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module test_dms_multiply_add_slice
    import dms_pkg::*;
;
    `include "dms_tb_cfg.svh"
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] ena = 4'hF;
    logic [3:0] aclr = 4'h0;
    logic [1:0] sign_a = '0;
    logic [1:0] sign_b = '0;
    logic [1:0][2:0] shift_op = '0;
    logic [1:0][3:0][17:0] data_a;
    logic [1:0][3:0][17:0] data_b;
    logic [17:0] scan_in = '0;
    logic [43:0] chain_in = '0;
    logic [1:0][71:0] result;
    logic narrow = 1'h1;
    integer seed = 32'hF812;
    int n_errors = 0;
    int checks = 0;
    longint acc;
    logic [31:0] rd;
    logic er;
    logic sat_seen = 1'h0;
    always #50 clock = ~clock;
    dms_block DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ena(ena), .aclr(aclr), .sign_a(sign_a), .sign_b(sign_b),
        .shift_op(shift_op), .data_a(data_a), .data_b(data_b), .scan_in(scan_in),
        .scan_out(), .chain_in(chain_in), .chain_out(), .result(result));
    dms_fabric u_fabric (.clock(clock), .narrow(narrow), .data_a(data_a), .data_b(data_b));
    function automatic longint mul(input int h, input int k);
        longint x;
        longint y;
        x = sign_a[h] ? longint'($signed(data_a[h][k])) : longint'(data_a[h][k]);
        y = sign_b[h] ? longint'($signed(data_b[h][k])) : longint'(data_b[h][k]);
        return x * y;
    endfunction
    function automatic longint pair(input int h, input int k, input bit sub);
        return sub ? mul(h, k) - mul(h, k + 1) : mul(h, k) + mul(h, k + 1);
    endfunction
    task automatic end_of_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd = prdata;
        er = pslverr;
        if (n >= 16) begin
            n_errors++;
            end_of_test();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic run(input int n, input int k);
        logic [7:0] s;
        longint hist[$];
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            s = 8'($random(seed));
            aclr <= 4'h0;
            chain_in <= 44'({$random(seed), $random(seed)});
            scan_in <= 18'($random(seed));
            shift_op[1] <= 3'(i % 5);
            ena <= {2'h3, s[0] | (k != 2), 1'h1};
            narrow <= (k == 0);
            if (k < 2) begin
                sign_a <= s[2:1];
                sign_b <= s[4:3];
            end else begin
                sign_a <= '0;
                sign_b <= '0;
            end
            @(negedge clock);
            if (k == 0) begin
                `CHK(result[0], {36'(mul(0, 1)), 36'(mul(0, 0))})
                `CHK(result[1], {36'(pair(1, 2, 1)), 36'(pair(1, 0, 1))})
            end else if (k == 1) begin
                `CHK(result[0][43:0], 44'(pair(0, 0, 0) + pair(0, 2, 0) + chain_in))
                `CHK(result[1][31:0], dms_shf({data_a[1][1][13:0], data_a[1][0]},
                    data_b[1][0][4:0], shift_op[1]))
            end else if (k == 2) begin
                `CHK(result[0][43:0], 44'(acc))
                acc += pair(0, 0, 0) + pair(0, 2, 0);
            end else if (k == 3) begin
                hist.push_back(mul(0, 0));
                if (i >= 3) `CHK(result[0][35:0], 36'(hist[i - 3]))
            end else if (k == 4) begin
                acc = (pair(0, 0, 0) + pair(0, 2, 0) + 8) / 16 * 16;
                if (acc > 64'hF_FFFF_FFFF) begin
                    acc = 64'hF_FFFF_FFFF;
                    sat_seen = 1'h1;
                end
                `CHK(result[0][43:0], 44'(acc))
                hist.push_back(data_a[0][3]);
                if (i >= 2) `CHK(result[1][35:0], 36'(hist[i - 1] * data_b[1][0]))
                if (i >= 2) `CHK(result[1][71:36], 36'(hist[i - 2] * data_b[1][1]))
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            apb(1'h0, 12'(4 * i), '0);
            `CHK(rd, 32'h0)
        end
        apb(1'h0, 12'h00C, '0);
        `CHK({er, rd}, 33'h1_0000_0000)
        apb(1'h1, OFS_CTRL0, 32'hFFFF_FFFF);
        apb(1'h0, OFS_CTRL0, '0);
        `CHK(rd, CTRL_MASK)
        apb(1'h1, OFS_CTRL0, C_MUL);
        apb(1'h1, OFS_CTRL1, C_ADD2);
        run(24, 0);
        apb(1'h1, OFS_CTRL0, C_ADD4);
        apb(1'h1, OFS_CTRL1, C_SHF);
        run(20, 1);
        apb(1'h1, OFS_CTRL0, C_RS);
        apb(1'h1, OFS_CTRL1, C_TAP);
        run(8, 4);
        apb(1'h0, OFS_STATUS, '0);
        `CHK(rd, {31'h0, sat_seen})
        apb(1'h1, OFS_CTRL0, C_REG);
        apb(1'h1, OFS_STATUS, 32'h0000_0003);
        apb(1'h0, OFS_STATUS, '0);
        `CHK(rd, 32'h0)
        run(8, 3);
        apb(1'h1, OFS_CTRL0, C_MAC);
        apb(1'h1, OFS_CTRL1, C_HLD);
        @(posedge clock);
        aclr <= 4'h1;
        acc = 0;
        run(30, 2);
        @(posedge clock);
        aclr <= 4'h1;
        @(negedge clock);
        `CHK(result[0], 72'h0)
        end_of_test();
    end
endmodule
